/* File: shared/anps_pkg.sv */
// constants for the auto-negotiation partner status register bank
// assumes a 5-bit management address space and 16-bit registers
package anps_pkg;

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [4:0] OFF_PARTNER = 5'h05;
	localparam logic [4:0] OFF_EXPANSION = 5'h06;
	localparam logic [4:0] OFF_CONFIG = 5'h1C;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h1D;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h1E;

	// ----------------------------------------
	// partner ability fields
	// ----------------------------------------
	localparam int PA_NP = 15;
	localparam int PA_ACK = 14;
	localparam int PA_RF = 13;
	localparam int PA_TECH_HI = 12;
	localparam int PA_TECH_LO = 5;
	localparam int PA_SEL_HI = 4;
	localparam int PA_SEL_LO = 0;
	localparam int TECH_PAUSE = 10;
	localparam int TECH_T4 = 9;
	localparam int TECH_TX_FD = 8;
	localparam int TECH_TX_HD = 7;
	localparam int TECH_10_FD = 6;
	localparam int TECH_10_HD = 5;
	localparam logic [4:0] SEL_IEEE = 5'h01;
	localparam logic [15:0] PARTNER_RST = 16'h0000;

	// ----------------------------------------
	// expansion fields
	// ----------------------------------------
	localparam int EX_PD_FAULT = 4;
	localparam int EX_LP_NP = 3;
	localparam int EX_NP_ABLE = 2;
	localparam int EX_PAGE_RX = 1;
	localparam int EX_LP_AN = 0;
	localparam logic NP_ABLE_RST = 1'b1;

	// ----------------------------------------
	// configuration and interrupt fields
	// ----------------------------------------
	localparam int CFG_LEGACY = 0;
	localparam logic CFG_LEGACY_RST = 1'b0;
	localparam int IRQ_W = 3;
	localparam int IRQ_PAGE = 0;
	localparam int IRQ_PD_FAULT = 1;
	localparam int IRQ_RFAULT = 2;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

endpackage

/* File: rtl/anps_page_capture.sv */
// holds the first received page as base page, later pages as next pages
// assumes page_valid_i is a one-cycle pulse from the arbitration logic
module anps_page_capture (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic page_valid_i,
	input wire logic [15:0] page_word_i,
	input wire logic an_restart_i,
	output logic [15:0] base_page_o,
	output logic base_valid_o,
	output logic [15:0] next_page_o,
	output logic next_valid_o
);

	// ----------------------------------------
	// base page latch
	// ----------------------------------------
	// base page stays frozen until a restart, so next pages never disturb it
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_page_o <= anps_pkg::PARTNER_RST;
			base_valid_o <= 1'b0;
		end else if (an_restart_i) begin
			base_page_o <= anps_pkg::PARTNER_RST;
			base_valid_o <= 1'b0;
		end else if (page_valid_i && !base_valid_o) begin
			base_page_o <= page_word_i;
			base_valid_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// next page latch
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			next_page_o <= 16'h0000;
			next_valid_o <= 1'b0;
		end else begin
			next_valid_o <= page_valid_i && base_valid_o && !an_restart_i;
			if (page_valid_i && base_valid_o && !an_restart_i) begin
				next_page_o <= page_word_i;
			end
		end
	end

endmodule

/* File: rtl/anps_irq.sv */
// sticky event status, read-to-clear, masked onto one level interrupt
// assumes clr_i pulses in the cycle the status register is read
module anps_irq #(
	parameter int W = 3
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] set_i,
	input wire logic clr_i,
	input wire logic mask_we_i,
	input wire logic [W-1:0] mask_wdata_i,
	output logic [W-1:0] status_o,
	output logic [W-1:0] mask_o,
	output logic irq_o
);

	// ----------------------------------------
	// sticky bits
	// ----------------------------------------
	// set wins over clear so an event in the read cycle is kept
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				status_o[i] <= 1'b0;
			end else if (set_i[i]) begin
				status_o[i] <= 1'b1;
			end else if (clr_i) begin
				status_o[i] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// mask
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_o <= W'(anps_pkg::IRQ_MASK_RST);
		end else if (mask_we_i) begin
			mask_o <= mask_wdata_i;
		end
	end

	assign irq_o = |(status_o & mask_o);

endmodule

/* File: rtl/anps_regs.sv */
// partner ability and expansion status registers of auto-negotiation
// assumes arbitration logic drives page and parallel-detect pulses
// synchronous to clk_sys_i, and a management port with one-cycle strobes
//
// Overview of operation
// - partner ability bit 15 shows partner next-page capability
// - partner ability bit 14 shows partner acknowledge
// - partner fault with autoneg enabled raises basic status remote fault
// - bits 12:5 hold partner technologies, reset zero, set means advertised
// - tech bits: pause, T4, TX full, TX half, 10 full, 10 half
// - bits 4:0 hold received selector, reset zero
// - expansion bit 4 set when both links valid, cleared by read
// - bit 4 also set when a link comes up but is lost
// - expansion bit 3 shows partner next-page ability
// - expansion bit 2 shows local next-page support, reset one
// - legacy mode bit at 1Ch disables local next-page bit
// - first page is base page, later pages are next pages
// - expansion bit 0 shows partner autoneg ability
// - selector 00001 means IEEE 802.3 messages
module anps_regs (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic page_valid_i,
	input wire logic [15:0] page_word_i,
	input wire logic an_restart_i,
	input wire logic an_enable_i,
	input wire logic partner_an_able_i,
	input wire logic pd_both_up_i,
	input wire logic pd_link_lost_i,
	output logic remote_fault_o,
	output logic partner_ieee_o,
	output logic [5:0] partner_caps_o,
	output logic [15:0] next_page_o,
	output logic next_valid_o,
	output logic irq_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	// pause, T4, TX full, TX half, 10 full, 10 half
	function automatic logic [5:0] caps(input logic [15:0] pa);
		caps = {pa[anps_pkg::TECH_PAUSE], pa[anps_pkg::TECH_T4],
			pa[anps_pkg::TECH_TX_FD], pa[anps_pkg::TECH_TX_HD],
			pa[anps_pkg::TECH_10_FD], pa[anps_pkg::TECH_10_HD]};
	endfunction

	logic [15:0] partner;
	logic base_valid;
	logic rd_exp;
	logic rd_irq;
	logic wr_cfg;
	logic wr_mask;
	logic pd_fault_r;
	logic page_rx_r;
	logic lp_an_r;
	logic legacy_r;
	logic rf_prev_r;
	logic [15:0] expansion;
	logic [15:0] rdata_nxt;
	logic [anps_pkg::IRQ_W-1:0] irq_set;
	logic [anps_pkg::IRQ_W-1:0] irq_status;
	logic [anps_pkg::IRQ_W-1:0] irq_mask;

	assign rd_exp = rd_i && hit(addr_i, anps_pkg::OFF_EXPANSION);
	assign rd_irq = rd_i && hit(addr_i, anps_pkg::OFF_IRQ_STAT);
	// partner and expansion offsets have no write path at all
	assign wr_cfg = wr_i && hit(addr_i, anps_pkg::OFF_CONFIG);
	assign wr_mask = wr_i && hit(addr_i, anps_pkg::OFF_IRQ_MASK);

	// ----------------------------------------
	// page capture
	// ----------------------------------------
	anps_page_capture u_capture (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.page_valid_i(page_valid_i),
		.page_word_i(page_word_i),
		.an_restart_i(an_restart_i),
		.base_page_o(partner),
		.base_valid_o(base_valid),
		.next_page_o(next_page_o),
		.next_valid_o(next_valid_o)
	);

	// ----------------------------------------
	// partner decode
	// ----------------------------------------
	// decode only trusted for IEEE messages; other selectors report nothing
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			partner_ieee_o <= 1'b0;
			partner_caps_o <= 6'h00;
		end else begin
			partner_ieee_o <= (partner[anps_pkg::PA_SEL_HI:anps_pkg::PA_SEL_LO]
				== anps_pkg::SEL_IEEE);
			if (partner[anps_pkg::PA_SEL_HI:anps_pkg::PA_SEL_LO] == anps_pkg::SEL_IEEE) begin
				partner_caps_o <= caps(partner);
			end else begin
				partner_caps_o <= 6'h00;
			end
		end
	end

	// ----------------------------------------
	// remote fault to basic status
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			remote_fault_o <= 1'b0;
			rf_prev_r <= 1'b0;
		end else begin
			remote_fault_o <= an_enable_i && partner[anps_pkg::PA_RF];
			rf_prev_r <= partner[anps_pkg::PA_RF];
		end
	end

	// ----------------------------------------
	// expansion status bits
	// ----------------------------------------
	// event in the read cycle wins, so no fault is ever lost
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pd_fault_r <= 1'b0;
		end else if (pd_both_up_i || pd_link_lost_i) begin
			pd_fault_r <= 1'b1;
		end else if (rd_exp) begin
			pd_fault_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page_rx_r <= 1'b0;
		end else if (page_valid_i) begin
			page_rx_r <= 1'b1;
		end else if (rd_exp) begin
			page_rx_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lp_an_r <= 1'b0;
		end else begin
			lp_an_r <= partner_an_able_i;
		end
	end

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			legacy_r <= anps_pkg::CFG_LEGACY_RST;
		end else if (wr_cfg) begin
			legacy_r <= wdata_i[anps_pkg::CFG_LEGACY];
		end
	end

	always_comb begin
		expansion = 16'h0000;
		expansion[anps_pkg::EX_PD_FAULT] = pd_fault_r;
		expansion[anps_pkg::EX_LP_NP] = partner[anps_pkg::PA_NP];
		// local support is fixed; legacy mode hides it
		expansion[anps_pkg::EX_NP_ABLE] = anps_pkg::NP_ABLE_RST && !legacy_r;
		expansion[anps_pkg::EX_PAGE_RX] = page_rx_r;
		expansion[anps_pkg::EX_LP_AN] = lp_an_r;
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign irq_set[anps_pkg::IRQ_PAGE] = page_valid_i;
	assign irq_set[anps_pkg::IRQ_PD_FAULT] = pd_both_up_i || pd_link_lost_i;
	assign irq_set[anps_pkg::IRQ_RFAULT] = partner[anps_pkg::PA_RF] && !rf_prev_r;

	anps_irq #(
		.W(anps_pkg::IRQ_W)
	) u_irq (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.set_i(irq_set),
		.clr_i(rd_irq),
		.mask_we_i(wr_mask),
		.mask_wdata_i(wdata_i[anps_pkg::IRQ_W-1:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// data valid only the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_nxt = 16'h0000;
		if (rd_i) begin
			unique case (1'b1)
				hit(addr_i, anps_pkg::OFF_PARTNER): rdata_nxt = partner;
				hit(addr_i, anps_pkg::OFF_EXPANSION): rdata_nxt = expansion;
				hit(addr_i, anps_pkg::OFF_CONFIG): rdata_nxt[anps_pkg::CFG_LEGACY] = legacy_r;
				hit(addr_i, anps_pkg::OFF_IRQ_STAT): rdata_nxt[anps_pkg::IRQ_W-1:0] = irq_status;
				hit(addr_i, anps_pkg::OFF_IRQ_MASK): rdata_nxt[anps_pkg::IRQ_W-1:0] = irq_mask;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 16'h0000;
		end else begin
			rdata_o <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	a_base_page_load: assert property (
		page_valid_i && !base_valid && !an_restart_i |=> partner == $past(page_word_i)
	) else $error("base page not captured");

	a_base_page_hold: assert property (
		base_valid && !an_restart_i |=> $stable(partner)
	) else $error("base page overwritten by next page");

	a_next_page_out: assert property (
		page_valid_i && base_valid && !an_restart_i |=> next_valid_o && next_page_o == $past(page_word_i)
	) else $error("next page not delivered");

	a_remote_fault_map: assert property (
		an_enable_i && partner[anps_pkg::PA_RF] ##1 an_enable_i && $stable(partner) |-> remote_fault_o
	) else $error("remote fault not mirrored");

	a_pd_fault_set: assert property (
		pd_both_up_i |=> pd_fault_r
	) else $error("parallel fault not set");

	a_pd_link_lost: assert property (
		pd_link_lost_i ##1 !rd_exp ##1 rd_exp |=> rdata_o[anps_pkg::EX_PD_FAULT]
	) else $error("lost link fault not reported");

	a_page_rx_clear: assert property (
		rd_exp && !page_valid_i |=> !page_rx_r ##0 rdata_o[anps_pkg::EX_PAGE_RX] == $past(page_rx_r)
	) else $error("page received not cleared by read");

	a_np_legacy_off: assert property (
		rd_exp && legacy_r |=> !rdata_o[anps_pkg::EX_NP_ABLE]
	) else $error("next page able seen in legacy mode");

	a_exp_reserved: assert property (
		rd_exp |=> rdata_o[15:5] == 11'h000 && rdata_o[anps_pkg::EX_LP_NP] == $past(partner[anps_pkg::PA_NP])
	) else $error("expansion reserved or partner np wrong");

	a_partner_no_write: assert property (
		wr_i && addr_i == anps_pkg::OFF_PARTNER && !page_valid_i && !an_restart_i |=> $stable(partner)
	) else $error("partner register changed by write");

	c_base_then_next: cover property (
		page_valid_i && !base_valid ##[1:20] page_valid_i && base_valid
	);
	c_pd_fault_read: cover property (pd_link_lost_i ##[1:10] rd_exp);
	c_irq_raised: cover property (!irq_o ##1 irq_o);

endmodule

/* File: dv/anps_lp_model.sv */
// link partner side: hands checked code words to the register bank
// assumes the bench calls send() from one thread, one word at a time
module anps_lp_model (
	input wire logic clk_sys_i,
	output logic page_valid_o,
	output logic [15:0] page_word_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] held_r;
	logic [15:0] idle_r;

	// ----------------------------------------
	// idle word churns so stale data never looks valid
	// ----------------------------------------
	initial begin
		page_valid_o = 1'b0;
		held_r = 16'h0000;
		idle_r = 16'hA5C3;
	end

	always @(posedge clk_sys_i) begin
		idle_r <= idle_r + 16'h3B1D;
	end

	assign page_word_o = page_valid_o ? held_r : idle_r;

	// ----------------------------------------
	// one word, valid for exactly one cycle
	// ----------------------------------------
	task automatic send(input logic [15:0] w);
		@(posedge clk_sys_i);
		held_r <= w;
		page_valid_o <= 1'b1;
		@(posedge clk_sys_i);
		page_valid_o <= 1'b0;
	endtask
endmodule

/* File: dv/autoneg_partner_status_regs_tb.sv */
// self-checking bench for the partner ability and expansion registers
// assumes the bank answers reads one cycle later and never stalls
module autoneg_partner_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0, rd = 1'b0, restart = 1'b0, an_en = 1'b1;
	logic lp_an = 1'b0, pd_up = 1'b0, pd_lost = 1'b0;
	logic [15:0] rdata, np, pw, d, w;
	logic rf, ieee, nv, irq, pv;
	logic [5:0] caps;
	int bad_count = 0;
	int comparisons = 0;

	// ----------------------------------------
	// clock, partner and design
	// ----------------------------------------
	initial begin
		forever #2.5 clk = ~clk;
	end

	anps_lp_model lp (.clk_sys_i(clk), .page_valid_o(pv), .page_word_o(pw));

	anps_regs dut (.clk_sys_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .page_valid_i(pv), .page_word_i(pw),
		.an_restart_i(restart), .an_enable_i(an_en), .partner_an_able_i(lp_an),
		.pd_both_up_i(pd_up), .pd_link_lost_i(pd_lost), .remote_fault_o(rf),
		.partner_ieee_o(ieee), .partner_caps_o(caps), .next_page_o(np),
		.next_valid_o(nv), .irq_o(irq));

	// ----------------------------------------
	// expectations and checks
	// ----------------------------------------
	function automatic logic [5:0] exp_caps(input logic [15:0] x);
		return (x[4:0] == anps_pkg::SEL_IEEE) ? x[10:5] : 6'h00;
	endfunction

	function automatic logic [15:0] exp_ex(input logic pd, np_lp, leg, prx, an);
		return {11'h000, pd, np_lp, ~leg, prx, an};
	endfunction

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t flag %b expected %b", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// watchdog: a hang ends as a mismatch
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		w = 16'($urandom(47));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(anps_pkg::OFF_PARTNER, d);
		chk16(d, anps_pkg::PARTNER_RST);
		rd_reg(anps_pkg::OFF_EXPANSION, d);
		chk16(d, 16'h0004);
		rd_reg(5'h1F, d);
		chk16(d, 16'h0000);
		wr_reg(anps_pkg::OFF_IRQ_MASK, 16'h0007);
		$display("test reset done");
		// random base pages; odd selector and all-ones ability bits with IEEE selector (FFE1) as corners
		for (int i = 0; i < 6; i++) begin
			w = 16'($urandom);
			if (i != 3) w[4:0] = anps_pkg::SEL_IEEE;
			if (i == 0) w = 16'hFFE1;
			if (i == 1) w[13] = 1'b1;
			@(posedge clk);
			an_en <= i[0];
			lp_an <= i[1];
			restart <= 1'b1;
			@(posedge clk);
			restart <= 1'b0;
			rd_reg(anps_pkg::OFF_IRQ_STAT, d);
			lp.send(w);
			#1;
			chk1(nv, 1'b0);
			@(posedge clk);
			#1;
			chk16(16'(caps), 16'(exp_caps(w)));
			chk1(ieee, w[4:0] == anps_pkg::SEL_IEEE);
			chk1(rf, an_en & w[13]);
			chk1(irq, 1'b1);
			rd_reg(anps_pkg::OFF_PARTNER, d);
			chk16(d, w);
			rd_reg(anps_pkg::OFF_EXPANSION, d);
			chk16(d, exp_ex(1'b0, w[15], 1'b0, 1'b1, lp_an));
			rd_reg(anps_pkg::OFF_EXPANSION, d);
			chk16(d, exp_ex(1'b0, w[15], 1'b0, 1'b0, lp_an));
			lp.send(~w);
			#1;
			chk1(nv, 1'b1);
			chk16(np, ~w);
			rd_reg(anps_pkg::OFF_PARTNER, d);
			chk16(d, w);
			rd_reg(anps_pkg::OFF_IRQ_STAT, d);
			chk1(d[anps_pkg::IRQ_PAGE], 1'b1);
			chk1(irq, 1'b0);
			$display("test page %0d done", i);
		end
		// parallel detect faults, masked so the line stays low
		wr_reg(anps_pkg::OFF_IRQ_MASK, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pd_up <= (k == 0);
			pd_lost <= (k == 1);
			@(posedge clk);
			pd_up <= 1'b0;
			pd_lost <= 1'b0;
			#1;
			chk1(irq, 1'b0);
			rd_reg(anps_pkg::OFF_EXPANSION, d);
			// the last next page of the loop left page received set
			chk16(d, exp_ex(1'b1, w[15], 1'b0, k == 0, lp_an));
			rd_reg(anps_pkg::OFF_EXPANSION, d);
			chk16(d, exp_ex(1'b0, w[15], 1'b0, 1'b0, lp_an));
			rd_reg(anps_pkg::OFF_IRQ_STAT, d);
			chk1(d[anps_pkg::IRQ_PD_FAULT], 1'b1);
		end
		$display("test parallel detect done");
		// writes refused, legacy mode hides local next-page bit
		wr_reg(anps_pkg::OFF_PARTNER, ~w);
		wr_reg(anps_pkg::OFF_EXPANSION, 16'hFFFF);
		wr_reg(anps_pkg::OFF_CONFIG, 16'h0001);
		rd_reg(anps_pkg::OFF_PARTNER, d);
		chk16(d, w);
		rd_reg(anps_pkg::OFF_EXPANSION, d);
		chk16(d, exp_ex(1'b0, w[15], 1'b1, 1'b0, lp_an));
		wr_reg(anps_pkg::OFF_CONFIG, 16'h0000);
		rd_reg(anps_pkg::OFF_EXPANSION, d);
		chk16(d, exp_ex(1'b0, w[15], 1'b0, 1'b0, lp_an));
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		rd_reg(anps_pkg::OFF_PARTNER, d);
		chk16(d, 16'h0000);
		$display("test writes and restart done");
		finish_test();
	end
endmodule
